/* File: core/sdc_pkg.sv */
// Purpose: shared types and constants for the two-bank command and state logic
// Assumes: one clock, synchronous active-high reset
// Notes: cycle counts are plain defaults, no timing figures are fixed for this block
package sdc_pkg;

  localparam int unsigned SDC_ADDR_W = 12;
  localparam int unsigned SDC_COL_W = 8;
  localparam int unsigned SDC_DATA_W = 16;
  localparam int unsigned SDC_CNT_W = 9;
  localparam int unsigned SDC_BANK_BIT = 11;
  localparam int unsigned SDC_CLOSE_BIT = 10;
  localparam int unsigned SDC_NUM_BANKS = 2;

  // Default cycle counts, chosen freely
  localparam int unsigned SDC_BURST_LEN = 4;
  localparam int unsigned SDC_WREC_CYC = 2;
  localparam int unsigned SDC_PRE_CYC = 3;
  localparam int unsigned SDC_REF_CYC = 8;
  localparam int unsigned SDC_RENEW_PERIOD = 64;

  localparam logic [SDC_ADDR_W-1:0] SDC_SETUP_RST = 12'h000;

  typedef struct packed {
    logic chip_pick_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_strobe_n;
  } sdc_strobes_type;

  typedef struct packed {
    logic high_lane_gate;
    logic low_lane_gate;
  } sdc_lanes_type;

  typedef enum logic [7:0] {
    SDC_CMD_NONE = 8'h01,
    SDC_CMD_HALT = 8'h02,
    SDC_CMD_READ = 8'h04,
    SDC_CMD_STORE = 8'h08,
    SDC_CMD_OPEN = 8'h10,
    SDC_CMD_CLOSE = 8'h20,
    SDC_CMD_REFRESH = 8'h40,
    SDC_CMD_SETUP = 8'h80
  } sdc_cmd_type;

  typedef enum logic [7:0] {
    SDC_BK_IDLE = 8'h01,
    SDC_BK_ACTIVE = 8'h02,
    SDC_BK_READ = 8'h04,
    SDC_BK_WRITE = 8'h08,
    SDC_BK_READ_AC = 8'h10,
    SDC_BK_WRITE_AC = 8'h20,
    SDC_BK_WREC = 8'h40,
    SDC_BK_CLOSING = 8'h80
  } sdc_bank_state_type;

  typedef enum logic [3:0] {
    SDC_MD_RUN = 4'h1,
    SDC_MD_FREEZE = 4'h2,
    SDC_MD_SLEEP = 4'h4,
    SDC_MD_RENEW = 4'h8
  } sdc_mode_type;

endpackage

/* File: core/sdc_bank_fsm.sv */
// Purpose: state machine of one bank, burst column and burst counter
// Assumes: command already decoded and qualified by the clock gate
// Notes: hold_i freezes every register of the bank except illegal_q, which clears
module sdc_bank_fsm
  import sdc_pkg::*;
#(
  parameter int unsigned BURST_LEN = SDC_BURST_LEN,
  parameter int unsigned WREC_CYC = SDC_WREC_CYC,
  parameter int unsigned PRE_CYC = SDC_PRE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Command
  input wire logic hold_i,
  input sdc_pkg::sdc_cmd_type cmd_i,
  input wire logic hit_i,
  input wire logic autoclose_i,
  input wire logic [sdc_pkg::SDC_COL_W-1:0] col_i,
  // State
  output sdc_pkg::sdc_bank_state_type state_o,
  output logic [sdc_pkg::SDC_COL_W-1:0] col_o,
  output logic illegal_o
);
  import sdc_pkg::*;

  initial begin
    if (BURST_LEN < 1 || BURST_LEN >= (1 << SDC_CNT_W) || WREC_CYC < 1 || PRE_CYC < 1 ||
        WREC_CYC >= (1 << SDC_CNT_W) || PRE_CYC >= (1 << SDC_CNT_W)) begin
      $error("sdc_bank_fsm: counts out of range");
    end
  end

  localparam logic [SDC_CNT_W-1:0] BURST_LAST = SDC_CNT_W'(BURST_LEN - 1);
  localparam logic [SDC_CNT_W-1:0] WREC_LAST = SDC_CNT_W'(WREC_CYC - 1);
  localparam logic [SDC_CNT_W-1:0] PRE_LAST = SDC_CNT_W'(PRE_CYC - 1);
  localparam logic [SDC_CNT_W-1:0] CNT_ZERO = '0;

  sdc_bank_state_type state_q, state_d;
  logic [SDC_CNT_W-1:0] cnt_q, cnt_d;
  logic [SDC_COL_W-1:0] col_q, col_d;
  logic close_after_q, close_after_d;
  logic illegal_d, illegal_q;
  logic done;
  logic rd_hit, wr_hit, cl_hit;

  assign done = (cnt_q == CNT_ZERO);
  assign rd_hit = (cmd_i == SDC_CMD_READ) && hit_i;
  assign wr_hit = (cmd_i == SDC_CMD_STORE) && hit_i;
  assign cl_hit = (cmd_i == SDC_CMD_CLOSE) && hit_i;

  always_comb begin
    state_d = state_q;
    cnt_d = done ? cnt_q : cnt_q - 1'b1;
    col_d = col_q;
    close_after_d = close_after_q;
    illegal_d = 1'b0;
    if (rd_hit || wr_hit) begin
      // New burst at the supplied column, autoclose chosen per command [R18]
      cnt_d = BURST_LAST;
      col_d = col_i;
      close_after_d = autoclose_i;
    end else if (state_q inside {SDC_BK_READ, SDC_BK_WRITE, SDC_BK_READ_AC,
                                 SDC_BK_WRITE_AC}) begin
      col_d = col_q + 1'b1;
    end
    unique case (state_q)
      SDC_BK_IDLE: begin
        // Only a row open changes state here; close is a no-op [R6]
        if ((cmd_i == SDC_CMD_OPEN) && hit_i) state_d = SDC_BK_ACTIVE;
        if ((rd_hit || wr_hit)) illegal_d = 1'b1;
      end
      SDC_BK_ACTIVE: begin
        if (rd_hit) state_d = autoclose_i ? SDC_BK_READ_AC : SDC_BK_READ; // [R21] [R18]
        else if (wr_hit) state_d = autoclose_i ? SDC_BK_WRITE_AC : SDC_BK_WRITE; // [R21]
        else if (cl_hit) begin
          state_d = SDC_BK_CLOSING; // [R21]
          cnt_d = PRE_LAST;
        end else if (hit_i && (cmd_i inside {SDC_CMD_OPEN, SDC_CMD_REFRESH,
                                              SDC_CMD_SETUP})) illegal_d = 1'b1; // [R21]
      end
      SDC_BK_READ, SDC_BK_WRITE, SDC_BK_WREC: begin
        if (rd_hit) state_d = autoclose_i ? SDC_BK_READ_AC : SDC_BK_READ; // [R9] [R14]
        else if (wr_hit) state_d = autoclose_i ? SDC_BK_WRITE_AC : SDC_BK_WRITE; // [R10] [R15]
        else if (cl_hit) begin
          state_d = SDC_BK_CLOSING; // [R11] [R16]
          cnt_d = PRE_LAST;
        end else if ((cmd_i == SDC_CMD_HALT) && (state_q != SDC_BK_WREC)) begin
          state_d = SDC_BK_ACTIVE; // [R8] [R13]
        end else if (done) begin
          if (state_q == SDC_BK_READ) state_d = SDC_BK_ACTIVE; // [R7]
          else if (state_q == SDC_BK_WRITE) begin
            state_d = SDC_BK_WREC; // [R12]
            cnt_d = WREC_LAST;
          end else if (close_after_q) begin
            state_d = SDC_BK_CLOSING;
            cnt_d = PRE_LAST;
          end else state_d = SDC_BK_ACTIVE;
        end
        if (hit_i && (cmd_i inside {SDC_CMD_OPEN, SDC_CMD_REFRESH,
                                    SDC_CMD_SETUP})) illegal_d = 1'b1; // [R22]
      end
      SDC_BK_READ_AC, SDC_BK_WRITE_AC: begin
        // Controller stays quiet until the close; a halt or any command to this bank is flagged [R17]
        if (!(cmd_i inside {SDC_CMD_NONE}) && (hit_i || cmd_i == SDC_CMD_HALT)) begin
          illegal_d = 1'b1;
          state_d = state_q;
          cnt_d = done ? cnt_q : cnt_q - 1'b1;
          col_d = col_q + 1'b1;
          close_after_d = close_after_q;
        end
        if (done) begin
          if (state_q == SDC_BK_READ_AC) begin
            state_d = SDC_BK_CLOSING; // [R17] [R18]
            cnt_d = PRE_LAST;
          end else begin
            state_d = SDC_BK_WREC;
            cnt_d = WREC_LAST;
          end
        end
      end
      SDC_BK_CLOSING: begin
        if (done) state_d = SDC_BK_IDLE;
        if (rd_hit || wr_hit) begin
          illegal_d = 1'b1;
          cnt_d = done ? cnt_q : cnt_q - 1'b1;
          col_d = col_q;
        end
      end
      default: state_d = SDC_BK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= SDC_BK_IDLE;
      cnt_q <= CNT_ZERO;
      col_q <= '0;
      close_after_q <= 1'b0;
      illegal_q <= 1'b0;
    end else if (!hold_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      col_q <= col_d;
      close_after_q <= close_after_d;
      illegal_q <= illegal_d;
    end else begin
      illegal_q <= 1'b0;
    end
  end

  assign state_o = state_q;
  assign col_o = col_q;
  assign illegal_o = illegal_q;
endmodule

/* File: core/sdc_core.sv */
// Purpose: command decode, clock-gate modes and byte-lane gating of a two-bank DRAM
// Assumes: all pins except array_rd_data_i sampled on clk_sys_i rising edges after a two-stage synchroniser
// Notes: read data latency is not modelled; lanes follow the burst cycle directly
//
// Behaviour
// R1 - High lane gate high blocks upper byte writes and floats upper outputs.
// R2 - Low lane gate high blocks lower byte writes; gate low enables the byte.
// R3 - Lane gates honoured only when clock gate was high last cycle, lanes independent.
// R4 - Clock gate falling while a bank is active enters freeze, whatever the command.
// R5 - Clock gate rising ends freeze, ignoring all other inputs.
// R6 - Idle: nop/halt may sleep, reads/writes illegal, open, refresh, setup accepted.
// R7 - Read burst with nop runs to completion, then row active.
// R8 - Burst halt during read cuts the burst, bank back to row active.
// R9 - New read during read restarts burst at the new column.
// R10 - Write during read aborts the read and starts a write burst.
// R11 - Row close during read ends it, then closes the addressed bank or banks.
// R12 - Write burst with nop finishes, then enters write recovery.
// R13 - Burst halt during write stops data intake, bank back to row active.
// R14 - Read during write aborts it and starts a read at the new column.
// R15 - New write during write restarts at the new column.
// R16 - Row close during write ends it, then closes the chosen bank or banks.
// R17 - Read with autoclose continues on nop and closes the row when done.
// R18 - Autoclose line high closes the picked bank after the burst.
// R19 - Refresh with clock gate falling from idle enters autonomous renew.
// R20 - Sleep ends when clock gate rises with unselected or no-op command.
// R21 - Row active: read/write start bursts, close begins closing, others illegal; a halt here is ignored and not flagged.
// R22 - Controller never opens, refreshes or loads setup during a burst.
// R23 - Commands decoded on rising edges from strobes and clock gate history.
module sdc_core
  import sdc_pkg::*;
#(
  parameter int unsigned BURST_LEN = SDC_BURST_LEN,
  parameter int unsigned REF_CYC = SDC_REF_CYC,
  parameter int unsigned RENEW_PERIOD = SDC_RENEW_PERIOD
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Command pins
  input sdc_pkg::sdc_strobes_type strobes_i,
  input wire logic clock_gate_in_i,
  input wire logic [sdc_pkg::SDC_ADDR_W-1:0] addr_i,
  // Data pins
  input sdc_pkg::sdc_lanes_type lanes_i,
  input wire logic [sdc_pkg::SDC_DATA_W-1:0] dq_in_i,
  input wire logic [sdc_pkg::SDC_DATA_W-1:0] array_rd_data_i,
  output logic [sdc_pkg::SDC_DATA_W-1:0] dq_out_o,
  output logic [1:0] dq_oe_o,
  // Array side
  output logic [1:0] array_wr_lane_o,
  output logic [sdc_pkg::SDC_DATA_W-1:0] array_wr_data_o,
  output logic [sdc_pkg::SDC_COL_W-1:0] array_col_o,
  output logic array_bank_o,
  // Status
  output sdc_pkg::sdc_mode_type mode_o,
  output sdc_pkg::sdc_bank_state_type bank0_state_o,
  output sdc_pkg::sdc_bank_state_type bank1_state_o,
  output logic [sdc_pkg::SDC_ADDR_W-1:0] setup_word_o,
  output logic renew_pulse_o,
  output logic illegal_o
);
  import sdc_pkg::*;

  initial begin
    if (REF_CYC < 1 || REF_CYC >= (1 << SDC_CNT_W) || RENEW_PERIOD < 1 ||
        RENEW_PERIOD >= (1 << SDC_CNT_W)) begin
      $error("sdc_core: counts out of range");
    end
  end

  localparam logic [SDC_CNT_W-1:0] REF_LAST = SDC_CNT_W'(REF_CYC - 1);
  localparam logic [SDC_CNT_W-1:0] RENEW_LAST = SDC_CNT_W'(RENEW_PERIOD - 1);
  localparam logic [SDC_CNT_W-1:0] CNT_ZERO = '0;

  // Two-stage synchronisers, first stage read only by the second
  sdc_strobes_type strobes_m_q, strobes_q;
  sdc_lanes_type lanes_m_q, lanes_q;
  logic cke_m_q, cke_q, cke_prev_q;
  logic [SDC_ADDR_W-1:0] addr_m_q, addr_q;
  logic [SDC_DATA_W-1:0] dq_m_q, dq_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      strobes_m_q <= '1;
      strobes_q <= '1;
      lanes_m_q <= '1;
      lanes_q <= '1;
      cke_m_q <= 1'b0;
      cke_q <= 1'b0;
      cke_prev_q <= 1'b0;
      addr_m_q <= '0;
      addr_q <= '0;
      dq_m_q <= '0;
      dq_q <= '0;
    end else begin
      strobes_m_q <= strobes_i;
      strobes_q <= strobes_m_q;
      lanes_m_q <= lanes_i;
      lanes_q <= lanes_m_q;
      cke_m_q <= clock_gate_in_i;
      cke_q <= cke_m_q;
      cke_prev_q <= cke_q;
      addr_m_q <= addr_i;
      addr_q <= addr_m_q;
      dq_m_q <= dq_in_i;
      dq_q <= dq_m_q;
    end
  end

  // Command decode from the four strobes
  sdc_cmd_type pin_cmd;
  always_comb begin
    pin_cmd = SDC_CMD_NONE; // [R23]
    if (!strobes_q.chip_pick_n) begin
      unique case ({strobes_q.row_strobe_n, strobes_q.column_strobe_n,
                    strobes_q.write_strobe_n})
        3'h7: pin_cmd = SDC_CMD_NONE;
        3'h6: pin_cmd = SDC_CMD_HALT;
        3'h5: pin_cmd = SDC_CMD_READ;
        3'h4: pin_cmd = SDC_CMD_STORE;
        3'h3: pin_cmd = SDC_CMD_OPEN;
        3'h2: pin_cmd = SDC_CMD_CLOSE;
        3'h1: pin_cmd = SDC_CMD_REFRESH;
        3'h0: pin_cmd = SDC_CMD_SETUP;
      endcase
    end
  end

  sdc_mode_type mode_q;
  sdc_bank_state_type bank_state [SDC_NUM_BANKS];
  logic [SDC_COL_W-1:0] bank_col [SDC_NUM_BANKS];
  logic [SDC_NUM_BANKS-1:0] bank_illegal;
  logic [SDC_CNT_W-1:0] ref_cnt_q, renew_cnt_q;
  logic all_idle, cke_fall, cke_rise, run_cmd, hold;
  sdc_cmd_type cmd;

  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < SDC_NUM_BANKS; b++) begin
      if (bank_state[b] != SDC_BK_IDLE) all_idle = 1'b0;
    end
  end

  assign cke_fall = cke_prev_q && !cke_q;
  assign cke_rise = !cke_prev_q && cke_q;
  // Commands act only in run mode with the gate high last cycle and now [R23]
  assign run_cmd = (mode_q == SDC_MD_RUN) && cke_prev_q && cke_q && (ref_cnt_q == CNT_ZERO);
  assign cmd = run_cmd ? pin_cmd : SDC_CMD_NONE;
  assign hold = (mode_q != SDC_MD_RUN) || cke_fall;

  // Clock-gate modes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_q <= SDC_MD_RUN;
    end else begin
      unique case (mode_q)
        SDC_MD_RUN: begin
          if (cke_fall) begin
            if (!all_idle) mode_q <= SDC_MD_FREEZE; // [R4]
            else if (pin_cmd == SDC_CMD_REFRESH) mode_q <= SDC_MD_RENEW; // [R19]
            else mode_q <= SDC_MD_SLEEP; // [R6]
          end
        end
        SDC_MD_FREEZE: if (cke_rise) mode_q <= SDC_MD_RUN; // [R5]
        SDC_MD_RENEW: if (cke_rise) mode_q <= SDC_MD_RUN; // [R19]
        SDC_MD_SLEEP: begin
          // Rise with any other command keeps the device asleep
          if (cke_rise && (pin_cmd == SDC_CMD_NONE)) mode_q <= SDC_MD_RUN; // [R20]
        end
        default: mode_q <= SDC_MD_RUN;
      endcase
    end
  end

  // Autonomous renew tick while the gate stays low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      renew_cnt_q <= CNT_ZERO;
      renew_pulse_o <= 1'b0;
    end else if (mode_q == SDC_MD_RENEW) begin
      renew_pulse_o <= (renew_cnt_q == CNT_ZERO); // [R19]
      renew_cnt_q <= (renew_cnt_q == CNT_ZERO) ? RENEW_LAST : renew_cnt_q - 1'b1;
    end else begin
      renew_cnt_q <= CNT_ZERO;
      renew_pulse_o <= 1'b0;
    end
  end

  // Refresh and setup word, accepted only with both banks idle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ref_cnt_q <= CNT_ZERO;
      setup_word_o <= SDC_SETUP_RST;
    end else begin
      if (ref_cnt_q != CNT_ZERO) ref_cnt_q <= ref_cnt_q - 1'b1;
      else if ((cmd == SDC_CMD_REFRESH) && all_idle) ref_cnt_q <= REF_LAST; // [R6]
      if ((cmd == SDC_CMD_SETUP) && all_idle) setup_word_o <= addr_q; // [R6]
    end
  end

  // Bank machines; a close with autoclose line high hits both banks
  for (genvar b = 0; b < SDC_NUM_BANKS; b++) begin : g_bank
    logic pick;
    assign pick = (addr_q[SDC_BANK_BIT] == 1'(b)) ||
                  ((cmd == SDC_CMD_CLOSE) && addr_q[SDC_CLOSE_BIT]); // [R11] [R16]
    sdc_bank_fsm #(
      .BURST_LEN(BURST_LEN),
      .WREC_CYC(SDC_WREC_CYC),
      .PRE_CYC(SDC_PRE_CYC)
    ) u_bank (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .hold_i(hold),
      .cmd_i(cmd),
      .hit_i(pick),
      .autoclose_i(addr_q[SDC_CLOSE_BIT]),
      .col_i(addr_q[SDC_COL_W-1:0]),
      .state_o(bank_state[b]),
      .col_o(bank_col[b]),
      .illegal_o(bank_illegal[b])
    );
  end

  // Lane gates held from the last cycle with the clock gate high [R3]
  sdc_lanes_type gate_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) gate_q <= '1;
    else if (cke_prev_q) gate_q <= lanes_q; // [R3]
  end

  sdc_lanes_type gate_now;
  assign gate_now = cke_prev_q ? lanes_q : gate_q;

  logic bursting_rd, bursting_wr, burst_bank;
  always_comb begin
    bursting_rd = 1'b0;
    bursting_wr = 1'b0;
    burst_bank = 1'b0;
    for (int b = 0; b < SDC_NUM_BANKS; b++) begin
      if (bank_state[b] inside {SDC_BK_READ, SDC_BK_READ_AC}) begin
        bursting_rd = 1'b1;
        burst_bank = 1'(b);
      end
      if (bank_state[b] inside {SDC_BK_WRITE, SDC_BK_WRITE_AC}) begin
        bursting_wr = 1'b1;
        burst_bank = 1'(b);
      end
    end
  end

  // Data path; a frozen device writes nothing, but read output enables are not gated by hold
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      array_wr_lane_o <= 2'h0;
      dq_oe_o <= 2'h0;
      array_wr_data_o <= '0;
      dq_out_o <= '0;
      array_col_o <= '0;
      array_bank_o <= 1'b0;
    end else begin
      array_wr_lane_o[1] <= bursting_wr && !hold && !gate_now.high_lane_gate; // [R1]
      array_wr_lane_o[0] <= bursting_wr && !hold && !gate_now.low_lane_gate; // [R2]
      dq_oe_o[1] <= bursting_rd && !gate_now.high_lane_gate; // [R1]
      dq_oe_o[0] <= bursting_rd && !gate_now.low_lane_gate; // [R2]
      array_wr_data_o <= dq_q;
      dq_out_o <= array_rd_data_i;
      array_col_o <= bank_col[burst_bank];
      array_bank_o <= burst_bank;
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_o <= SDC_MD_RUN;
      bank0_state_o <= SDC_BK_IDLE;
      bank1_state_o <= SDC_BK_IDLE;
      illegal_o <= 1'b0;
    end else begin
      mode_o <= mode_q;
      bank0_state_o <= bank_state[0];
      bank1_state_o <= bank_state[1];
      // Read or write to an idle device counts as illegal too [R6]
      illegal_o <= |bank_illegal;
    end
  end
endmodule

/* File: tb/sdc_core_asserts.sv */
// Purpose: port-level checks of the bank states and clock-gate modes
// Assumes: one clock, synchronous active-high reset
// Notes: state changes are judged one sample apart, so output lag is harmless
module sdc_core_asserts
  import sdc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input sdc_pkg::sdc_mode_type mode_o,
  input sdc_pkg::sdc_bank_state_type bank0_state_o,
  input sdc_pkg::sdc_bank_state_type bank1_state_o,
  input wire logic [1:0] dq_oe_o,
  input wire logic renew_pulse_o,
  input wire logic illegal_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_reset_values: assert property ($fell(rst_i) |-> mode_o == SDC_MD_RUN &&
    bank0_state_o == SDC_BK_IDLE && bank1_state_o == SDC_BK_IDLE && dq_oe_o == 2'h0)
    else $error("outputs wrong after reset");
  chk_idle_exit: assert property ($past(bank0_state_o) == SDC_BK_IDLE &&
    bank0_state_o != SDC_BK_IDLE |-> bank0_state_o == SDC_BK_ACTIVE)
    else $error("idle bank left to a state other than row active");
  chk_read_exit: assert property ($past(bank0_state_o) == SDC_BK_READ &&
    bank0_state_o != SDC_BK_READ |-> !(bank0_state_o inside {SDC_BK_IDLE, SDC_BK_WREC}))
    else $error("read burst ended in a wrong state");
  chk_write_exit: assert property ($past(bank0_state_o) == SDC_BK_WRITE &&
    bank0_state_o != SDC_BK_WRITE |-> bank0_state_o != SDC_BK_IDLE)
    else $error("write burst fell straight to idle");
  chk_closing_end: assert property ($past(bank0_state_o) == SDC_BK_CLOSING &&
    bank0_state_o != SDC_BK_CLOSING |-> bank0_state_o == SDC_BK_IDLE)
    else $error("row close did not end in idle");
  chk_freeze_hold: assert property (mode_o == SDC_MD_FREEZE &&
    $past(mode_o) == SDC_MD_FREEZE && $past(mode_o, 2) == SDC_MD_FREEZE
    |-> $stable(bank0_state_o) && $stable(bank1_state_o))
    else $error("bank state moved while frozen");
  chk_sleep_idle: assert property (mode_o == SDC_MD_SLEEP &&
    $past(mode_o) == SDC_MD_RUN |-> bank0_state_o == SDC_BK_IDLE)
    else $error("sleep entered with a bank open");
  chk_illegal_pulse: assert property (illegal_o |=> !illegal_o)
    else $error("illegal flag held longer than one cycle");
  chk_renew_pulse: assert property (renew_pulse_o |->
    (mode_o == SDC_MD_RENEW || $past(mode_o) == SDC_MD_RENEW) ##1 !renew_pulse_o)
    else $error("renew pulse outside renew mode or too long");
  chk_onehot_codes: assert property ($onehot(mode_o) &&
    $onehot(bank0_state_o) && $onehot(bank1_state_o))
    else $error("mode or bank state not one-hot");
  cov_freeze: cover property (mode_o == SDC_MD_FREEZE);
endmodule

bind sdc_core sdc_core_asserts u_sdc_core_asserts (.clk_sys_i, .rst_i, .mode_o,
  .bank0_state_o, .bank1_state_o, .dq_oe_o, .renew_pulse_o, .illegal_o);

/* File: tb/sdc_ctrl_model.sv */
// Purpose: memory controller model that issues single-cycle commands
// Assumes: pins change on the falling edge only
// Notes: released address and write data never keep their last value
module sdc_ctrl_model
  import sdc_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Command and data pins
  output sdc_pkg::sdc_strobes_type strobes_o,
  output logic clock_gate_o,
  output logic [sdc_pkg::SDC_ADDR_W-1:0] addr_o,
  output logic [sdc_pkg::SDC_DATA_W-1:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    strobes_o = 4'hF;
    clock_gate_o = 1'b1;
    addr_o = 12'h000;
    dq_o = 16'h3C5A;
  end

  // Toggling data exposes any lane that should have been blocked
  always @(negedge clk_sys_i) begin
    dq_o <= ~dq_o;
  end

  // Commands are spaced by a no-op, never opening or refreshing mid-burst
  task automatic issue(input logic [3:0] code, input logic [11:0] adr, input logic gate);
    @(negedge clk_sys_i);
    strobes_o <= code;
    addr_o <= adr;
    clock_gate_o <= gate;
    @(negedge clk_sys_i);
    strobes_o <= 4'h7;
    addr_o <= ~adr;
  endtask
endmodule

/* File: tb/sdc_core_tb.sv */
// Purpose: self-checking bench of bank states, lane gating and clock-gate modes
// Assumes: default burst and renew counts, commands from the controller model
// Notes: read latency is not modelled, so lanes are judged over whole windows
module sdc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdc_pkg::*;

  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  sdc_strobes_type strobes;
  logic gate;
  logic [11:0] addr;
  sdc_lanes_type lanes = 2'b00;
  logic [15:0] dq_in;
  logic [15:0] rd_data = 16'h1E2D;
  logic [1:0] dq_oe_o, array_wr_lane_o;
  sdc_mode_type mode_o;
  sdc_bank_state_type bank0_state_o, bank1_state_o;
  logic [11:0] setup_word_o;
  logic renew_pulse_o, illegal_o;
  int err_count = 0;
  int checked = 0;
  int rd_cnt;
  logic [1:0] oe_or, wl_or;
  logic il, wr, pl;

  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) begin
    rd_data <= {rd_data[14:0], ~rd_data[15]};
  end

  sdc_ctrl_model u_sdc_ctrl_model (.clk_sys_i(clk_sys_i), .strobes_o(strobes),
    .clock_gate_o(gate), .addr_o(addr), .dq_o(dq_in));
  sdc_core #(.BURST_LEN(4), .REF_CYC(8), .RENEW_PERIOD(64)) u_sdc_core (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .strobes_i(strobes), .clock_gate_in_i(gate),
    .addr_i(addr), .lanes_i(lanes), .dq_in_i(dq_in), .array_rd_data_i(rd_data),
    .dq_out_o(), .dq_oe_o(dq_oe_o), .array_wr_lane_o(array_wr_lane_o),
    .array_wr_data_o(), .array_col_o(), .array_bank_o(), .mode_o(mode_o),
    .bank0_state_o(bank0_state_o), .bank1_state_o(bank1_state_o),
    .setup_word_o(setup_word_o), .renew_pulse_o(renew_pulse_o), .illegal_o(illegal_o));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic watch(input int n);
    {rd_cnt, oe_or, wl_or, il, wr, pl} = '0;
    repeat (n) begin
      @(negedge clk_sys_i);
      rd_cnt += int'(bank0_state_o inside {SDC_BK_READ, SDC_BK_WRITE});
      oe_or |= dq_oe_o;
      wl_or |= array_wr_lane_o;
      il |= illegal_o;
      wr |= (bank0_state_o === SDC_BK_WREC);
      pl |= renew_pulse_o;
    end
  endtask

  task automatic wait_bank(input logic b, input logic [7:0] exp);
    int n;
    n = 0;
    while ((b ? bank1_state_o : bank0_state_o) !== exp && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("bank_state", b ? bank1_state_o : bank0_state_o, exp);
    if (n == 40) print_verdict();
  endtask

  task automatic wait_mode(input logic [3:0] exp);
    int n;
    n = 0;
    while (mode_o !== exp && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("mode", mode_o, exp);
    if (n == 40) print_verdict();
  endtask

  task automatic open_row();
    u_sdc_ctrl_model.issue(4'h3, 12'h000, 1'b1);
    wait_bank(1'b0, SDC_BK_ACTIVE);
  endtask

  task automatic t_idle();
    check("reset_mode", mode_o, SDC_MD_RUN);
    u_sdc_ctrl_model.issue(4'h5, 12'h000, 1'b1);
    watch(12);
    check("idle_read_illegal", il, 1'b1);
    u_sdc_ctrl_model.issue(4'h2, 12'h000, 1'b1);
    watch(12);
    check("idle_close_nop", {il, bank0_state_o}, {1'b0, SDC_BK_IDLE});
    u_sdc_ctrl_model.issue(4'h0, 12'h023, 1'b1);
    watch(8);
    check("setup_word", setup_word_o, 12'h023);
  endtask

  task automatic t_banks();
    u_sdc_ctrl_model.issue(4'h3, 12'h800, 1'b1);
    wait_bank(1'b1, SDC_BK_ACTIVE);
    check("bank0_untouched", bank0_state_o, SDC_BK_IDLE);
    open_row();
    u_sdc_ctrl_model.issue(4'h2, 12'h400, 1'b1);
    wait_bank(1'b0, SDC_BK_IDLE);
    wait_bank(1'b1, SDC_BK_IDLE);
  endtask

  task automatic t_read();
    lanes = 2'b10;
    open_row();
    u_sdc_ctrl_model.issue(4'h1, 12'h000, 1'b1);
    watch(8);
    check("active_refresh_illegal", {il, bank0_state_o}, {1'b1, SDC_BK_ACTIVE});
    u_sdc_ctrl_model.issue(4'h5, 12'h010, 1'b1);
    watch(16);
    check("read_len", rd_cnt, 4);
    check("read_lanes", oe_or, 2'b01);
    check("read_end", bank0_state_o, SDC_BK_ACTIVE);
    u_sdc_ctrl_model.issue(4'h5, 12'h010, 1'b1);
    u_sdc_ctrl_model.issue(4'h6, 12'h000, 1'b1);
    watch(16);
    check("halted_read_short", rd_cnt < 4, 1'b1);
    check("halted_read_end", bank0_state_o, SDC_BK_ACTIVE);
    u_sdc_ctrl_model.issue(4'h5, 12'h010, 1'b1);
    u_sdc_ctrl_model.issue(4'h5, 12'h020, 1'b1);
    watch(16);
    check("restarted_read_long", rd_cnt > 4, 1'b1);
    u_sdc_ctrl_model.issue(4'h5, 12'h010, 1'b1);
    u_sdc_ctrl_model.issue(4'h4, 12'h030, 1'b1);
    wait_bank(1'b0, SDC_BK_WRITE);
    wait_bank(1'b0, SDC_BK_ACTIVE);
    lanes = 2'b00;
  endtask

  task automatic t_write();
    lanes = 2'b01;
    u_sdc_ctrl_model.issue(4'h4, 12'h040, 1'b1);
    watch(12);
    check("write_lanes", wl_or, 2'b10);
    check("write_recovery", wr, 1'b1);
    lanes = 2'b00;
    u_sdc_ctrl_model.issue(4'h4, 12'h040, 1'b1);
    u_sdc_ctrl_model.issue(4'h6, 12'h000, 1'b1);
    watch(12);
    check("halted_write", {wr, bank0_state_o}, {1'b0, SDC_BK_ACTIVE});
    u_sdc_ctrl_model.issue(4'h4, 12'h040, 1'b1);
    u_sdc_ctrl_model.issue(4'h4, 12'h060, 1'b1);
    watch(16);
    check("restarted_write_long", rd_cnt > 4, 1'b1);
    u_sdc_ctrl_model.issue(4'h4, 12'h040, 1'b1);
    u_sdc_ctrl_model.issue(4'h5, 12'h050, 1'b1);
    wait_bank(1'b0, SDC_BK_READ);
    wait_bank(1'b0, SDC_BK_ACTIVE);
    u_sdc_ctrl_model.issue(4'h4, 12'h040, 1'b1);
    u_sdc_ctrl_model.issue(4'h2, 12'h000, 1'b1);
    wait_bank(1'b0, SDC_BK_CLOSING);
    wait_bank(1'b0, SDC_BK_IDLE);
  endtask

  task automatic t_autoclose();
    open_row();
    u_sdc_ctrl_model.issue(4'h5, 12'h410, 1'b1);
    wait_bank(1'b0, SDC_BK_READ_AC);
    wait_bank(1'b0, SDC_BK_IDLE);
  endtask

  task automatic t_modes();
    open_row();
    u_sdc_ctrl_model.issue(4'h5, 12'h000, 1'b0);
    wait_mode(SDC_MD_FREEZE);
    u_sdc_ctrl_model.issue(4'h2, 12'h000, 1'b1);
    wait_mode(SDC_MD_RUN);
    wait_bank(1'b0, SDC_BK_ACTIVE);
    u_sdc_ctrl_model.issue(4'h2, 12'h000, 1'b1);
    wait_bank(1'b0, SDC_BK_IDLE);
    u_sdc_ctrl_model.issue(4'h7, 12'h000, 1'b0);
    wait_mode(SDC_MD_SLEEP);
    u_sdc_ctrl_model.issue(4'h7, 12'h000, 1'b1);
    wait_mode(SDC_MD_RUN);
    watch(8);
    u_sdc_ctrl_model.issue(4'h1, 12'h000, 1'b0);
    wait_mode(SDC_MD_RENEW);
    watch(80);
    check("renew_pulse", pl, 1'b1);
    u_sdc_ctrl_model.issue(4'h7, 12'h000, 1'b1);
    wait_mode(SDC_MD_RUN);
  endtask

  initial begin
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    t_idle();
    t_banks();
    t_read();
    t_write();
    t_autoclose();
    t_modes();
    print_verdict();
  end
endmodule
